//--- shared/clk_ctrl_pkg.sv
// Constants and types shared by the clock mode controller and its rate generator.
// Assumes a single 200 MHz system clock; the external input clock is modelled as an enable pulse.
`default_nettype none

package clk_ctrl_pkg;
	// I/O space decode.
	localparam logic [15:0] LOOP_CTRL_ADDR = 16'h0200;
	localparam logic [15:0] LOCK_CNT_ADDR = 16'h0201;
	localparam logic [7:0] CLOCK_SYS_PAGE = 8'h00;

	// Control register field positions.
	localparam int INPUT_HALVING_BIT = 0;
	localparam int PLL_SHUTOFF_BIT = 1;
	localparam int HALT_ALL_BIT = 2;
	localparam int HALT_CORE_BIT = 3;
	localparam int PERIPH_RATIO_BIT = 4;
	localparam int LOW_POWER_BIT = 5;
	localparam int CLK_PIN_EN_BIT = 6;
	localparam int BYPASS_HALVING_BIT = 7;
	localparam int DIRECT_PATH_BIT = 8;
	localparam int RATIO_LSB = 9;
	localparam int RATIO_W = 7;

	// Reset value of every bit below the strapped fields.
	localparam logic [15:0] CTRL_RESET_LOW = 16'h0000;

	// Lock counter status word.
	localparam int LOCK_W = 10;
	localparam int LOCKED_BIT = 15;

	// Stabilisation time of the loop, counted in input clock cycles.
	localparam int LOCK_INPUT_CYCLES = 500;

	// System clock cycles per input clock cycle in the model; 32x must fit under it.
	localparam int CLKIN_DIV_DEFAULT = 64;
	localparam int MAX_RATIO = 32;
	localparam int ACC_W = 10;

	typedef enum logic [1:0] {
		MODE_PASS,
		MODE_LOCK,
		MODE_MULT,
		MODE_PDALL
	} mode_e;
endpackage : clk_ctrl_pkg

`default_nettype wire

//--- src/rate_gen.sv
// Fractional rate generator: emits a one-cycle tick at incr/modulus of the system clock rate.
// Assumes incr never exceeds modulus, so at most one tick is due per cycle.
`default_nettype none

module rate_gen #(
	parameter int W = clk_ctrl_pkg::ACC_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic clear,
	input wire logic [W-1:0] incr,
	input wire logic [W-1:0] modulus,
	// Output
	output logic tick
);
	logic [W:0] acc_q;
	logic [W:0] sum;

	assign sum = acc_q + {1'b0, incr};

	// Clearing restarts a full period so the first tick after a source change is never early.
	always_ff @(posedge clock)
	begin
		if (sys_rst || clear || !run)
		begin
			acc_q <= '0;
			tick <= 1'b0;
		end
		else if (sum >= {1'b0, modulus})
		begin
			acc_q <= sum - {1'b0, modulus};
			tick <= 1'b1;
		end
		else
		begin
			acc_q <= sum;
			tick <= 1'b0;
		end
	end
endmodule : rate_gen

`default_nettype wire

//--- src/pll_clock_mode_control.sv
// Clock mode controller: derives core, peripheral, external-memory and pin clocks from the input clock.
// Assumes I/O writes are single-cycle strobes and strap pins are stable while sys_rst is high.
//
// Functional notes
// [R1] All clocks derive from the one input clock.
// [R2] Multiplier scales input by 1x to 32x.
// [R3] Reset captures ratio, direct-path, halving pins.
// [R4] Reset leaves core on pass-through input clock.
// [R5] Stay pass-through until lock counter expires.
// [R6] Lock counter readable for software polling.
// [R7] System sets halving pin above 100 MHz.
// [R8] Bit 0 halves input before loop.
// [R9] Bit 1 shuts off the loop.
// [R10] Bit 2 holds core, peripheral clocks high.
// [R11] Bit 3 holds core clock high.
// [R12] Bit 4 makes peripheral half core rate.
// [R13] Bit 5 powers down loop, stops input.
// [R14] Bit 6 puts peripheral clock on pin.
// [R15] Bit 7 halves core in pass-through.
// [R16] Bit 8 selects pass-through or multiplier.
// [R17] Bits 15-9 strapped ratio select field.
// [R18] Control register at 0x200, page 0x00.
// [R19] Software keeps core, peripheral clocks within limits.
// [R20] Input clock runs through reset, never altered.
// [R21] Reset held until synchronizers initialise.
// [R22] Software follows the ratio change order.
// [R23] Fixed priority; low-power plus shutoff gives power-down; code also requires bit 8 (direct path) set.
// [R24] Ratio bit 5 requires input halving set.
// [R25] Source switching is glitch-free.
`default_nettype none

module pll_clock_mode_control #(
	parameter int CLKIN_DIV = clk_ctrl_pkg::CLKIN_DIV_DEFAULT,
	parameter int LOCK_CYCLES = clk_ctrl_pkg::LOCK_INPUT_CYCLES,
	parameter int NUM_BANKS = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Strap pins sampled during reset
	input wire logic [6:0] ratio_pins,
	input wire logic direct_path_pin,
	input wire logic input_halving_pin,
	// I/O space access
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_page,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	// Wake-up from power-down-all
	input wire logic wake_event,
	// Derived clock enables and levels
	output logic core_clock_en,
	output logic periph_clock_en,
	output logic [NUM_BANKS-1:0] ext_mem_clock_en,
	output logic core_clock_level,
	output logic periph_clock_level,
	output logic clock_pin_out,
	// Status
	output clk_ctrl_pkg::mode_e mode
);
	logic [15:0] ctrl_q;
	logic [clk_ctrl_pkg::LOCK_W-1:0] lock_cnt_q;
	clk_ctrl_pkg::mode_e mode_q;
	clk_ctrl_pkg::mode_e mode_d;
	logic src_mult_q;
	logic pass_half_q;
	logic periph_div_q;
	logic clkin_tick;
	logic vco_tick;
	logic pass_tick;
	logic raw_core;
	logic periph_tick;
	logic loop_on;
	logic wr_ctrl;
	logic ctrl_page;
	logic [4:0] ratio_low;
	logic [5:0] ratio_mult;
	logic [1:0] den_shift;
	logic [clk_ctrl_pkg::ACC_W-1:0] vco_mod;
	logic [clk_ctrl_pkg::ACC_W-1:0] vco_incr;
	logic vco_clear;

	wire logic halving = ctrl_q[clk_ctrl_pkg::INPUT_HALVING_BIT];
	wire logic shutoff = ctrl_q[clk_ctrl_pkg::PLL_SHUTOFF_BIT];
	wire logic halt_all = ctrl_q[clk_ctrl_pkg::HALT_ALL_BIT];
	wire logic halt_core = ctrl_q[clk_ctrl_pkg::HALT_CORE_BIT];
	wire logic periph_half = ctrl_q[clk_ctrl_pkg::PERIPH_RATIO_BIT];
	wire logic low_power = ctrl_q[clk_ctrl_pkg::LOW_POWER_BIT];
	wire logic pin_en = ctrl_q[clk_ctrl_pkg::CLK_PIN_EN_BIT];
	wire logic bypass_halving = ctrl_q[clk_ctrl_pkg::BYPASS_HALVING_BIT];
	wire logic direct_path = ctrl_q[clk_ctrl_pkg::DIRECT_PATH_BIT];
	wire logic [6:0] ratio_field = ctrl_q[clk_ctrl_pkg::RATIO_LSB +: clk_ctrl_pkg::RATIO_W];

	assign ctrl_page = (io_page == clk_ctrl_pkg::CLOCK_SYS_PAGE);
	assign wr_ctrl = io_wr && ctrl_page && (io_addr == clk_ctrl_pkg::LOOP_CTRL_ADDR); // [R18]
	assign loop_on = !shutoff && !low_power; // [R9] [R13]
	assign mode = mode_q;

	// Control register; the strap fields load from the pins for as long as reset is held.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ctrl_q <= clk_ctrl_pkg::CTRL_RESET_LOW;
			ctrl_q[clk_ctrl_pkg::RATIO_LSB +: clk_ctrl_pkg::RATIO_W] <= ratio_pins; // [R3] [R17]
			ctrl_q[clk_ctrl_pkg::DIRECT_PATH_BIT] <= direct_path_pin; // [R3]
			ctrl_q[clk_ctrl_pkg::INPUT_HALVING_BIT] <= input_halving_pin; // [R3]
		end
		else if (wr_ctrl)
		begin
			ctrl_q <= io_wdata;
		end
		else if (mode_q == clk_ctrl_pkg::MODE_PDALL && wake_event)
		begin
			ctrl_q[clk_ctrl_pkg::LOW_POWER_BIT] <= 1'b0;
			ctrl_q[clk_ctrl_pkg::PLL_SHUTOFF_BIT] <= 1'b0;
		end
	end

	// Register reads answer one cycle later; anything unmapped reads as zero.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			io_rdata <= 16'h0000;
		end
		else if (io_rd && ctrl_page && io_addr == clk_ctrl_pkg::LOOP_CTRL_ADDR)
		begin
			io_rdata <= ctrl_q;
		end
		else if (io_rd && ctrl_page && io_addr == clk_ctrl_pkg::LOCK_CNT_ADDR)
		begin
			io_rdata <= 16'h0000;
			io_rdata[clk_ctrl_pkg::LOCK_W-1:0] <= lock_cnt_q; // [R6]
			io_rdata[clk_ctrl_pkg::LOCKED_BIT] <= (lock_cnt_q == '0) && loop_on;
		end
		else if (io_rd)
		begin
			io_rdata <= 16'h0000;
		end
	end

	// The modelled input clock, one tick per CLKIN_DIV system cycles.
	rate_gen #(
		.W(clk_ctrl_pkg::ACC_W)
	) u_clkin (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(1'b1),
		.clear(1'b0),
		.incr(clk_ctrl_pkg::ACC_W'(1)),
		.modulus(clk_ctrl_pkg::ACC_W'(CLKIN_DIV)),
		.tick(clkin_tick)
	); // [R1]

	// Ratio 0 means 32x; ratio bit 6 halves the core, and ratio bit 5 cancels the input halving.
	assign ratio_low = ratio_field[4:0];
	assign ratio_mult = (ratio_low == 5'h00) ? 6'(clk_ctrl_pkg::MAX_RATIO) : {1'b0, ratio_low}; // [R2]
	assign den_shift = {1'b0, ratio_field[6]} + {1'b0, halving ^ ratio_field[5]}; // [R8] [R24]
	assign vco_mod = clk_ctrl_pkg::ACC_W'(CLKIN_DIV) << den_shift;
	assign vco_incr = clk_ctrl_pkg::ACC_W'(ratio_mult);
	assign vco_clear = clkin_tick && (src_mult_q != (mode_q == clk_ctrl_pkg::MODE_MULT)); // [R25]

	rate_gen #(
		.W(clk_ctrl_pkg::ACC_W)
	) u_vco (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(loop_on),
		.clear(vco_clear),
		.incr(vco_incr),
		.modulus(vco_mod),
		.tick(vco_tick)
	); // [R2]

	// Lock counter reloads whenever the loop is off or reconfigured, counts input cycles otherwise.
	always_ff @(posedge clock)
	begin
		if (sys_rst || !loop_on || wr_ctrl)
		begin
			lock_cnt_q <= clk_ctrl_pkg::LOCK_W'(LOCK_CYCLES); // [R5]
		end
		else if (clkin_tick && lock_cnt_q != '0)
		begin
			lock_cnt_q <= lock_cnt_q - clk_ctrl_pkg::LOCK_W'(1); // [R6]
		end
	end

	// Mode arbitration; power-down-all outranks every other move.
	always_comb
	begin
		mode_d = mode_q;
		if (mode_q != clk_ctrl_pkg::MODE_PDALL && low_power && shutoff && direct_path)
		begin
			mode_d = clk_ctrl_pkg::MODE_PDALL; // [R23]
		end
		else
		begin
			case (mode_q)
				clk_ctrl_pkg::MODE_PASS:
				begin
					if (!direct_path && loop_on)
					begin
						mode_d = clk_ctrl_pkg::MODE_LOCK; // [R16]
					end
				end
				clk_ctrl_pkg::MODE_LOCK:
				begin
					if (direct_path || !loop_on)
					begin
						mode_d = clk_ctrl_pkg::MODE_PASS;
					end
					else if (lock_cnt_q == '0)
					begin
						mode_d = clk_ctrl_pkg::MODE_MULT; // [R5]
					end
				end
				clk_ctrl_pkg::MODE_MULT:
				begin
					if (direct_path || !loop_on)
					begin
						mode_d = clk_ctrl_pkg::MODE_PASS; // [R16]
					end
				end
				clk_ctrl_pkg::MODE_PDALL:
				begin
					if (wake_event)
					begin
						mode_d = clk_ctrl_pkg::MODE_PASS;
					end
				end
				default:
				begin
					mode_d = clk_ctrl_pkg::MODE_PASS;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			mode_q <= clk_ctrl_pkg::MODE_PASS; // [R4]
		end
		else
		begin
			mode_q <= mode_d;
		end
	end

	// The source only changes on an input clock edge, so neither stream is cut short.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			src_mult_q <= 1'b0; // [R4]
		end
		else if (clkin_tick)
		begin
			src_mult_q <= (mode_q == clk_ctrl_pkg::MODE_MULT); // [R25]
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pass_half_q <= 1'b0;
		end
		else if (clkin_tick)
		begin
			pass_half_q <= !pass_half_q;
		end
	end

	assign pass_tick = clkin_tick && (!bypass_halving || pass_half_q); // [R15]
	assign raw_core = (mode_q != clk_ctrl_pkg::MODE_PDALL) && (src_mult_q ? vco_tick : pass_tick); // [R13]

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			periph_div_q <= 1'b0;
		end
		else if (raw_core)
		begin
			periph_div_q <= !periph_div_q;
		end
	end

	assign periph_tick = raw_core && (!periph_half || periph_div_q) && !halt_all; // [R12] [R10]

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			core_clock_en <= 1'b0;
			periph_clock_en <= 1'b0;
			ext_mem_clock_en <= '0;
		end
		else
		begin
			core_clock_en <= raw_core && !halt_all && !halt_core; // [R10] [R11]
			periph_clock_en <= periph_tick;
			ext_mem_clock_en <= {NUM_BANKS{periph_tick}}; // [R1]
		end
	end

	// Clock levels toggle on each tick and sit high while halted.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			core_clock_level <= 1'b1;
			periph_clock_level <= 1'b1;
		end
		else
		begin
			if (halt_all || halt_core)
			begin
				core_clock_level <= 1'b1; // [R11]
			end
			else if (raw_core)
			begin
				core_clock_level <= !core_clock_level;
			end
			if (halt_all)
			begin
				periph_clock_level <= 1'b1; // [R10]
			end
			else if (periph_tick)
			begin
				periph_clock_level <= !periph_clock_level;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || !pin_en)
		begin
			clock_pin_out <= 1'b0; // [R14]
		end
		else if (halt_all)
		begin
			clock_pin_out <= 1'b1;
		end
		else if (periph_tick)
		begin
			clock_pin_out <= !periph_clock_level; // [R14]
		end
	end

	sequence s_pdall_request;
		low_power && shutoff && direct_path && mode_q != clk_ctrl_pkg::MODE_PDALL;
	endsequence

	sequence s_enter_pdall;
		##1 mode_q == clk_ctrl_pkg::MODE_PDALL;
	endsequence

	property p_pdall_priority;
		@(posedge clock) disable iff (sys_rst) s_pdall_request |-> s_enter_pdall;
	endproperty
	a_pdall_priority: assert property (p_pdall_priority) else $error("power-down-all not entered"); // [R23]

	property p_no_mult_before_lock;
		@(posedge clock) disable iff (sys_rst)
			$rose(mode_q == clk_ctrl_pkg::MODE_MULT) |-> $past(lock_cnt_q) == '0;
	endproperty
	a_no_mult_before_lock: assert property (p_no_mult_before_lock) else $error("multiplier used before lock"); // [R5]

	property p_reset_pass;
		@(posedge clock) $fell(sys_rst) |-> mode_q == clk_ctrl_pkg::MODE_PASS && !src_mult_q;
	endproperty
	a_reset_pass: assert property (p_reset_pass) else $error("not in pass-through after reset"); // [R4]

	property p_strap_capture;
		@(posedge clock) $fell(sys_rst) |-> ratio_field == $past(ratio_pins)
			&& direct_path == $past(direct_path_pin) && halving == $past(input_halving_pin);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap pins not captured"); // [R3]

	property p_halt_core;
		@(posedge clock) disable iff (sys_rst) halt_core && !wr_ctrl |=> !core_clock_en && core_clock_level;
	endproperty
	a_halt_core: assert property (p_halt_core) else $error("core clock runs while halted"); // [R11]

	property p_halt_all;
		@(posedge clock) disable iff (sys_rst)
			halt_all && !wr_ctrl |=> !core_clock_en && !periph_clock_en && periph_clock_level;
	endproperty
	a_halt_all: assert property (p_halt_all) else $error("clocks run under halt-all"); // [R10]

	property p_pin_off;
		@(posedge clock) disable iff (sys_rst) !pin_en |=> !clock_pin_out;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("clock pin driven while disabled"); // [R14]

	property p_switch_on_edge;
		@(posedge clock) disable iff (sys_rst) $changed(src_mult_q) |-> $past(clkin_tick);
	endproperty
	a_switch_on_edge: assert property (p_switch_on_edge) else $error("source switched off an input edge"); // [R25]

	property p_lock_reload;
		@(posedge clock) disable iff (sys_rst) !loop_on |=> lock_cnt_q == clk_ctrl_pkg::LOCK_W'(LOCK_CYCLES);
	endproperty
	a_lock_reload: assert property (p_lock_reload) else $error("lock counter not reloaded"); // [R6]

	property p_pass_halving;
		@(posedge clock) disable iff (sys_rst)
			!src_mult_q && bypass_halving && clkin_tick && !pass_half_q |-> !raw_core;
	endproperty
	a_pass_halving: assert property (p_pass_halving) else $error("pass-through not halved"); // [R15]
endmodule : pll_clock_mode_control

`default_nettype wire

//--- test/board_straps.sv
// Board strap model for the clock mode controller: ratio, pass-through and halving pins.
// Assumes the board holds these levels steady through reset and afterwards.
`default_nettype none

module board_straps #(
	parameter int CLKIN_MHZ = 25,
	parameter logic [6:0] RATIO = 7'h02,
	parameter logic DIRECT = 1'b1
) (
	// Strap levels
	output logic [6:0] ratio_pins,
	output logic direct_path_pin,
	output logic input_halving_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	assign ratio_pins = RATIO;
	assign direct_path_pin = DIRECT;
	// A fast input and the upper ratio bank both need the input halved before the loop.
	assign input_halving_pin = (CLKIN_MHZ > 100) || RATIO[5];
endmodule : board_straps

`default_nettype wire

//--- test/pll_clock_mode_control_tb.sv
// Self-checking bench for the clock mode controller, driving its I/O port and wake input.
// Assumes the strap model above and a shortened input divider and lock count.
`default_nettype none

module pll_clock_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 32;
	logic clock, sys_rst, io_wr, io_rd, wake_event;
	logic [15:0] io_addr, io_wdata, io_rdata, rd;
	logic [7:0] io_page;
	logic [6:0] ratio_pins;
	logic direct_path_pin, input_halving_pin;
	logic core_clock_en, periph_clock_en, core_clock_level, periph_clock_level, clock_pin_out;
	logic [3:0] ext_mem_clock_en;
	clk_ctrl_pkg::mode_e mode;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int n_core, n_per, n_pin, n_mem;

	board_straps u_board_straps (
		.ratio_pins(ratio_pins),
		.direct_path_pin(direct_path_pin),
		.input_halving_pin(input_halving_pin)
	);

	pll_clock_mode_control #(.CLKIN_DIV(DIV), .LOCK_CYCLES(5), .NUM_BANKS(4)) u_pll_clock_mode_control (
		.clock(clock), .sys_rst(sys_rst),
		.ratio_pins(ratio_pins), .direct_path_pin(direct_path_pin), .input_halving_pin(input_halving_pin),
		.io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_page(io_page),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .wake_event(wake_event),
		.core_clock_en(core_clock_en), .periph_clock_en(periph_clock_en),
		.ext_mem_clock_en(ext_mem_clock_en), .core_clock_level(core_clock_level),
		.periph_clock_level(periph_clock_level), .clock_pin_out(clock_pin_out), .mode(mode)
	);

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// A counted rate may land one tick either side, depending on where the window starts.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input bit tol);
		check_count++;
		if (!(got === exp || (tol && (got + 16'h0001 === exp || got === exp + 16'h0001))))
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic io_write(input logic [15:0] addr, input logic [15:0] data, input logic [7:0] page);
		@(negedge clock);
		io_wr = 1'b1;
		io_addr = addr;
		io_wdata = data;
		io_page = page;
		@(negedge clock);
		io_wr = 1'b0;
		io_page = 8'h00;
	endtask : io_write

	task automatic io_read(input logic [15:0] addr, output logic [15:0] data);
		@(negedge clock);
		io_rd = 1'b1;
		io_addr = addr;
		@(negedge clock);
		io_rd = 1'b0;
		@(negedge clock);
		data = io_rdata;
	endtask : io_read

	// Lets the source switch settle, then counts ticks and pin high cycles over n cycles.
	task automatic watch(input int n);
		n_core = 0;
		n_per = 0;
		n_pin = 0;
		n_mem = 0;
		repeat (2 * DIV) @(negedge clock);
		repeat (n)
		begin
			@(negedge clock);
			n_core += core_clock_en;
			n_per += periph_clock_en;
			n_pin += clock_pin_out;
			n_mem += (ext_mem_clock_en !== {4{periph_clock_en}});
		end
	endtask : watch

	task automatic wait_lock();
		int i;
		i = 0;
		rd = 16'h0000;
		while (rd[15] !== 1'b1 && i < 100)
		begin
			io_read(16'h0201, rd);
			i++;
		end
		chk({15'h0000, rd[15]}, 16'h0001, 0);
	endtask : wait_lock

	task automatic t_reset();
		io_read(16'h0200, rd);
		chk(rd, 16'h0500, 0);
		chk({14'h0000, mode}, {14'h0000, clk_ctrl_pkg::MODE_PASS}, 0);
		watch(640);
		chk(16'(n_core), 16'h0014, 1);
		chk(16'(n_per), 16'h0014, 1);
		chk(16'(n_pin), 16'h0000, 0);
		chk(16'(n_mem), 16'h0000, 0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_pass_div();
		io_write(16'h0200, 16'h05d0, 8'h00);
		io_read(16'h0200, rd);
		chk(rd, 16'h05d0, 0);
		watch(640);
		chk(16'(n_core), 16'h000a, 1);
		chk(16'(n_per), 16'h0005, 1);
		chk({15'h0000, n_pin > 0}, 16'h0001, 0);
		$display("test pass divide done");
	endtask : t_pass_div

	task automatic t_halts();
		io_write(16'h0200, 16'h0508, 8'h00);
		watch(320);
		chk(16'(n_core), 16'h0000, 0);
		chk({15'h0000, core_clock_level}, 16'h0001, 0);
		chk(16'(n_per), 16'h000a, 1);
		io_write(16'h0200, 16'h0504, 8'h00);
		watch(320);
		chk(16'(n_core + n_per), 16'h0000, 0);
		chk({14'h0000, core_clock_level, periph_clock_level}, 16'h0003, 0);
		$display("test halts done");
	endtask : t_halts

	task automatic t_refuse();
		io_write(16'h0200, 16'hffff, 8'h01);
		io_read(16'h0200, rd);
		chk(rd, 16'h0504, 0);
		io_read(16'h0300, rd);
		chk(rd, 16'h0000, 0);
		$display("test decode done");
	endtask : t_refuse

	task automatic t_ratio();
		io_write(16'h0200, 16'h0352, 8'h00);
		io_read(16'h0201, rd);
		chk(rd, 16'h0005, 0);
		io_write(16'h0200, 16'h0552, 8'h00);
		io_write(16'h0200, 16'h0550, 8'h00);
		io_write(16'h0200, 16'h0450, 8'h00);
		// The mode register follows the control register one cycle later.
		@(negedge clock);
		chk({14'h0000, mode}, {14'h0000, clk_ctrl_pkg::MODE_LOCK}, 0);
		wait_lock();
		chk({14'h0000, mode}, {14'h0000, clk_ctrl_pkg::MODE_MULT}, 0);
		watch(640);
		chk(16'(n_core), 16'h0028, 1);
		chk(16'(n_per), 16'h0014, 1);
		io_write(16'h0200, 16'h0451, 8'h00);
		wait_lock();
		watch(640);
		chk(16'(n_core), 16'h0014, 1);
		$display("test ratio done");
	endtask : t_ratio

	task automatic t_pdall();
		io_write(16'h0200, 16'h0522, 8'h00);
		@(negedge clock);
		chk({14'h0000, mode}, {14'h0000, clk_ctrl_pkg::MODE_PDALL}, 0);
		watch(320);
		chk(16'(n_core + n_per), 16'h0000, 0);
		@(negedge clock);
		wake_event = 1'b1;
		@(negedge clock);
		wake_event = 1'b0;
		@(negedge clock);
		chk({14'h0000, mode}, {14'h0000, clk_ctrl_pkg::MODE_PASS}, 0);
		io_read(16'h0200, rd);
		chk(rd, 16'h0500, 0);
		$display("test power down done");
	endtask : t_pdall

	initial
	begin
		sys_rst = 1'b1;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 16'h0000;
		io_page = 8'h00;
		wake_event = 1'b0;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		t_reset();
		t_pass_div();
		t_halts();
		t_refuse();
		t_ratio();
		t_pdall();
		print_verdict();
	end

	// The tests need about 4300 cycles; the ceiling leaves ample margin.
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			print_verdict();
		end
	end
endmodule : pll_clock_mode_control_tb

`default_nettype wire
